// >>> dv/iof_count_model.sv
`timescale 1ns/100ps
module iof_count_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Quadrature and index lines
    input wire logic out_a,
    input wire logic out_b,
    input wire logic out_index,
    // Position seen by the counter
    output logic [15:0] pos_count
);
    logic [1:0] ab_q;

    // The index pulse zeroes the position, as an incremental counter does.
    always_ff @(posedge clk_sys) begin
        ab_q <= {out_a, out_b};
        if (reset || out_index) begin
            pos_count <= 16'h0000;
        end else if ({out_a, out_b} != ab_q) begin
            pos_count <= (ab_q[1] ^ out_b) ? pos_count + 16'h0001 : pos_count - 16'h0001;
        end
    end
endmodule : iof_count_model

// >>> dv/iof_regs_assertions.sv
`timescale 1ns/100ps
module iof_regs_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Access strobes and read data
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic cal_index_wr,
    input wire iof_pkg::iof_byte_t cfg_rdata,
    input wire logic cfg_rack,
    // Outputs
    input wire logic out_a,
    input wire logic out_b,
    input wire logic out_index,
    input wire logic out_u,
    input wire logic out_v,
    input wire logic out_w,
    input wire logic abz_enable,
    input wire logic uvw_enable,
    input wire logic readout_fast_rate,
    input wire iof_pkg::iof_phase_t index_phase_value,
    input wire iof_pkg::iof_phase_t commutation_phase_shift,
    input wire logic dynamic_gain_en,
    input wire logic [2:0] proportional_gain,
    input wire logic [2:0] gain_limit,
    input wire logic [3:0] lag_reduce_delay
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    a_abz_off: assert property (!abz_enable |-> !out_a && !out_b && !out_index)
        else $error("quadrature outputs active while disabled");
    a_uvw_off: assert property (!uvw_enable |-> !out_u && !out_v && !out_w)
        else $error("commutation outputs active while disabled");
    a_rate_follow: assert property (readout_fast_rate == abz_enable)
        else $error("readout rate does not follow quadrature enable");
    a_idx_cause: assert property ($changed(index_phase_value)
        |-> $past(cfg_wr, 2) || $past(cal_index_wr, 2))
        else $error("index phase changed without a write");
    a_uvw_cause: assert property ($changed(commutation_phase_shift) |-> $past(cfg_wr, 2))
        else $error("commutation phase changed without a write");
    a_fb_value: assert property (lag_reduce_delay == 4'h0 || lag_reduce_delay == 4'h6)
        else $error("loop delay not 0 or 6 cycles");
    a_limit_range: assert property (gain_limit >= 3'h3 && gain_limit <= 3'h6)
        else $error("gain limit outside 3 to 6");
    a_kp_range: assert property (proportional_gain <= 3'h6)
        else $error("proportional gain above 6");
    a_gain_step: assert property (dynamic_gain_en && $changed(proportional_gain)
        |-> proportional_gain == 3'($past(proportional_gain) + 3'h1)
        || proportional_gain == 3'($past(proportional_gain) - 3'h1))
        else $error("dynamic gain moved by more than one");
    a_kp_static: assert property (!dynamic_gain_en && !$past(dynamic_gain_en) && $changed(proportional_gain)
        |-> $past(cfg_wr, 2))
        else $error("static gain changed without a write");
    a_rack_pulse: assert property (cfg_rack == $past(cfg_rd))
        else $error("read acknowledge not one cycle after read");
    a_rdata_hold: assert property (!cfg_rack |-> $stable(cfg_rdata))
        else $error("read data moved without a read");
endmodule : iof_regs_checker

bind iof_regs iof_regs_checker u_iof_regs_checker (.*);

// >>> dv/iof_regs_bench.sv
`timescale 1ns/100ps
module iof_regs_bench;
    logic clk_sys, reset, cfg_wr, cfg_rd, cal_index_wr, lag_valid, cfg_rack, dynamic_gain_en;
    logic quad_a_raw, quad_b_raw, index_raw, comm_u_raw, comm_v_raw, comm_w_raw;
    logic out_a, out_b, out_index, out_u, out_v, out_w, abz_enable, uvw_enable, readout_fast_rate;
    iof_pkg::iof_addr_t cfg_addr;
    iof_pkg::iof_byte_t cfg_wdata, cfg_rdata, adc_index;
    iof_pkg::iof_phase_t index_phase_value, commutation_phase_shift, cal_index_phase;
    logic [11:0] adc_sine, adc_cosine;
    logic [4:0] filter_lag;
    logic [2:0] proportional_gain, gain_limit;
    logic [1:0] integral_gain;
    logic [3:0] lag_reduce_delay;
    logic [15:0] pos_count;
    int error_cnt, n_tests;
    logic [15:0] rst_adr [10] = '{16'h0109, 16'h010A, 16'h010B, 16'h010C, 16'h0300, 16'h0301,
                                  16'h0302, 16'h021A, 16'h021C, 16'h0200};
    logic [7:0] rst_val [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00};
    logic [7:0] ctl_tab [8] = '{8'h00, 8'h40, 8'h4F, 8'h4A, 8'h0F, 8'h80, 8'hB0, 8'h70};
    logic [5:0] raw_tab [3] = '{6'h22, 6'h2A, 6'h15};
    logic [1:0] ab_seq [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    logic [4:0] lag_tab [11] = '{5'h02, 5'h09, 5'h09, 5'h04, 5'h01, 5'h01, 5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1F};
    logic [2:0] kp_tab [11] = '{3'h5, 3'h4, 3'h3, 3'h3, 3'h4, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0};

    iof_regs u_iof_regs (.*);
    iof_count_model u_iof_count_model (.clk_sys, .reset, .out_a, .out_b, .out_index, .pos_count);

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge clk_sys);
        cfg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge clk_sys);
        cfg_rd = 1'b0;
        chk("cfg_rack", 12'h001, {11'h000, cfg_rack});
        chk("cfg_rdata", {4'h0, exp}, {4'h0, cfg_rdata});
    endtask : rd

    // Expected pin levels {a, b, index, u, v, w} for a control byte and raw inputs.
    function automatic logic [5:0] pins(input logic [7:0] c, input logic [5:0] r);
        logic a, b, z, u, v, w;
        {a, b, z, u, v, w} = 6'h00;
        if (c[6]) begin
            z = r[3] ^ c[2];
            a = r[3] ? c[0] : (c[3] ? r[4] : r[5]) ^ c[0];
            b = r[3] ? c[1] : (c[3] ? r[5] : r[4]) ^ c[1];
        end
        if (c[7]) begin
            u = r[2] ^ c[4];
            v = (c[5] ? r[0] : r[1]) ^ c[4];
            w = (c[5] ? r[1] : r[0]) ^ c[4];
        end
        return {a, b, z, u, v, w};
    endfunction : pins

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        {reset, cfg_wr, cfg_rd, cal_index_wr, lag_valid} = 5'h10;
        {quad_a_raw, quad_b_raw, index_raw, comm_u_raw, comm_v_raw, comm_w_raw} = 6'h00;
        cfg_addr = 16'h0000;
        cfg_wdata = 8'h00;
        cal_index_phase = 10'h000;
        filter_lag = 5'h00;
        adc_sine = 12'hABC;
        adc_cosine = 12'h5A5;
        adc_index = 8'h3C;
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        for (int i = 0; i < 10; i++) rd(rst_adr[i], rst_val[i]);
        chk("gains", 12'h01B, {6'h00, proportional_gain, gain_limit});
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            wr(16'h0109, ctl_tab[i]);
            for (int j = 0; j < 3; j++) begin
                @(negedge clk_sys);
                {quad_a_raw, quad_b_raw, index_raw, comm_u_raw, comm_v_raw, comm_w_raw} = raw_tab[j];
                repeat (2) @(negedge clk_sys);
                chk("pins", {6'h00, pins(ctl_tab[i], raw_tab[j])},
                    {6'h00, out_a, out_b, out_index, out_u, out_v, out_w});
                chk("enables", {9'h000, ctl_tab[i][7:6], ctl_tab[i][6]},
                    {9'h000, uvw_enable, abz_enable, readout_fast_rate});
            end
            rd(16'h0109, ctl_tab[i]);
        end
        @(negedge clk_sys);
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        rd(16'h0109, 8'h00);
        // The counter sees A leading B as down; the reversed direction must count up.
        for (int d = 0; d < 2; d++) begin
            wr(16'h0109, d ? 8'h48 : 8'h40);
            @(negedge clk_sys);
            {quad_a_raw, quad_b_raw, index_raw} = 3'h1;
            repeat (3) @(negedge clk_sys);
            index_raw = 1'b0;
            for (int k = 0; k < 4; k++) begin
                @(negedge clk_sys);
                {quad_a_raw, quad_b_raw} = ab_seq[k];
            end
            repeat (3) @(negedge clk_sys);
            chk("count", d ? 12'h004 : 12'hFFC, pos_count[11:0]);
        end
        $display("test output control done");
        wr(16'h010A, 8'hA5);
        wr(16'h010B, 8'h3C);
        wr(16'h010C, 8'hF6);
        rd(16'h010C, 8'h06);
        chk("index phase", 12'h296, {2'h0, index_phase_value});
        chk("comm phase", 12'h0F1, {2'h0, commutation_phase_shift});
        @(negedge clk_sys);
        cal_index_wr = 1'b1;
        cal_index_phase = 10'h123;
        @(negedge clk_sys);
        cal_index_wr = 1'b0;
        @(negedge clk_sys);
        chk("cal phase", 12'h123, {2'h0, index_phase_value});
        rd(16'h010A, 8'h48);
        rd(16'h010C, 8'h07);
        $display("test phases done");
        wr(16'h0300, 8'h02);
        rd(16'h0300, 8'h0E);
        chk("loop delay", 12'h006, {8'h00, lag_reduce_delay});
        wr(16'h0302, 8'h37);
        rd(16'h0302, 8'h33);
        wr(16'h0302, 8'h25);
        rd(16'h0302, 8'h25);
        chk("ki kp", 12'h015, {7'h00, integral_gain, proportional_gain});
        wr(16'h0301, 8'h00);
        rd(16'h0301, 8'h01);
        wr(16'h0301, 8'h04);
        wr(16'h0300, 8'h11);
        rd(16'h0300, 8'h11);
        chk("dyn cfg", 12'h018, {7'h00, dynamic_gain_en, gain_limit, lag_reduce_delay[3]});
        for (int i = 0; i < 11; i++) begin
            @(negedge clk_sys);
            lag_valid = 1'b1;
            filter_lag = lag_tab[i];
            @(negedge clk_sys);
            lag_valid = 1'b0;
            @(negedge clk_sys);
            chk("dyn kp", {9'h000, kp_tab[i]}, {9'h000, proportional_gain});
        end
        wr(16'h0302, 8'h26);
        rd(16'h0302, 8'h20);
        wr(16'h0300, 8'h00);
        rd(16'h0300, 8'h10);
        $display("test filter done");
        repeat (520) @(negedge clk_sys);
        rd(16'h021A, 8'hAB);
        rd(16'h021C, 8'h5A);
        rd(16'h020C, 8'h3C);
        wr(16'h021A, 8'hFF);
        wr(16'h0200, 8'h55);
        rd(16'h021A, 8'hAB);
        rd(16'h0200, 8'h00);
        adc_sine = 12'h123;
        repeat (510) @(negedge clk_sys);
        rd(16'h021A, 8'h12);
        $display("test snapshots done");
        complete_run();
    end
endmodule : iof_regs_bench

// >>> hdl/iof_defs.svh
`ifndef IOF_DEFS_SVH
`define IOF_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IOF_ADR_OUTPUT_CONTROL 16'h0109
`define IOF_ADR_INDEX_PHASE_HIGH 16'h010A
`define IOF_ADR_COMM_PHASE_HIGH 16'h010B
`define IOF_ADR_PHASE_LOW_BITS 16'h010C
`define IOF_ADR_INDEX_ADC 16'h020C
`define IOF_ADR_SINE_ADC 16'h021A
`define IOF_ADR_COSINE_ADC 16'h021C
`define IOF_ADR_FILTER_CONFIG 16'h0300
`define IOF_ADR_LAG_THRESHOLD 16'h0301
`define IOF_ADR_FILTER_COEFF 16'h0302

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IOF_OC_APOL 0
`define IOF_OC_BPOL 1
`define IOF_OC_ZPOL 2
`define IOF_OC_ABZDIR 3
`define IOF_OC_UVWPOL 4
`define IOF_OC_UVWDIR 5
`define IOF_OC_ABZEN 6
`define IOF_OC_UVWEN 7
`define IOF_FC_AUTO 0
`define IOF_FC_FB 1
`define IOF_FC_KPMAX_LO 2
`define IOF_FC_KPMAX_HI 4
`define IOF_FK_KP_HI 2
`define IOF_FK_KI_LO 4
`define IOF_FK_KI_HI 5
`define IOF_KPMAX_MIN 3'h3
`define IOF_KPMAX_MAX 3'h6
`define IOF_KP_MAX 3'h6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IOF_RST_OUTPUT_CONTROL 8'h00
`define IOF_RST_PHASE_HIGH 8'h00
`define IOF_RST_PHASE_LOW 4'h0
`define IOF_RST_FILTER_CONFIG 5'h0C
`define IOF_RST_LAG_THRESHOLD 5'h01
`define IOF_RST_KP 3'h3
`define IOF_RST_KI 2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define IOF_CLK_PERIOD_NS 100
`define IOF_SNAP_PERIOD_NS 50000
`define IOF_SNAP_CYCLES (`IOF_SNAP_PERIOD_NS / `IOF_CLK_PERIOD_NS)
`define IOF_FB_DELAY_NS 600
`define IOF_FB_DELAY_CYCLES (`IOF_FB_DELAY_NS / `IOF_CLK_PERIOD_NS)
`endif

// >>> hdl/iof_pkg.sv
package iof_pkg;
    typedef logic [7:0] iof_byte_t;
    typedef logic [9:0] iof_phase_t;
    typedef logic [15:0] iof_addr_t;
    typedef logic [9:0] iof_tick_t;
endpackage : iof_pkg

// >>> hdl/iof_regs.sv
`timescale 1ns/100ps
`include "iof_defs.svh"
module iof_regs (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Configuration access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire iof_pkg::iof_addr_t cfg_addr,
    input wire iof_pkg::iof_byte_t cfg_wdata,
    output iof_pkg::iof_byte_t cfg_rdata,
    output logic cfg_rack,
    // Raw output generator signals
    input wire logic quad_a_raw,
    input wire logic quad_b_raw,
    input wire logic index_raw,
    input wire logic comm_u_raw,
    input wire logic comm_v_raw,
    input wire logic comm_w_raw,
    // Conditioned outputs
    output logic out_a,
    output logic out_b,
    output logic out_index,
    output logic out_u,
    output logic out_v,
    output logic out_w,
    output logic abz_enable,
    output logic uvw_enable,
    output logic readout_fast_rate,
    // Phase settings
    output iof_pkg::iof_phase_t index_phase_value,
    output iof_pkg::iof_phase_t commutation_phase_shift,
    input wire logic cal_index_wr,
    input wire iof_pkg::iof_phase_t cal_index_phase,
    // ADC conversions
    input wire logic [11:0] adc_sine,
    input wire logic [11:0] adc_cosine,
    input wire iof_pkg::iof_byte_t adc_index,
    // Tracking filter
    input wire logic lag_valid,
    input wire logic [4:0] filter_lag,
    output logic dynamic_gain_en,
    output logic [2:0] proportional_gain,
    output logic [1:0] integral_gain,
    output logic [2:0] gain_limit,
    output logic [3:0] lag_reduce_delay
);

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    iof_pkg::iof_byte_t out_ctl_q;
    iof_pkg::iof_byte_t zph_hi_q;
    iof_pkg::iof_byte_t uvw_hi_q;
    logic [3:0] ph_lo_q;
    logic [4:0] filter_config_q;
    logic [4:0] lag_thr_q;
    logic [2:0] kp_q;
    logic [1:0] ki_q;
    iof_pkg::iof_byte_t snap_sin_q;
    iof_pkg::iof_byte_t snap_cos_q;
    iof_pkg::iof_byte_t snap_idx_q;
    iof_pkg::iof_byte_t rdata_q;
    logic rack_q;

    logic wr_oc, wr_zh, wr_uh, wr_pl, wr_fc, wr_lt, wr_fk;
    logic [2:0] kpmax_w;
    logic [2:0] kp_w;

    assign wr_oc = cfg_wr && (cfg_addr == `IOF_ADR_OUTPUT_CONTROL);
    assign wr_zh = cfg_wr && (cfg_addr == `IOF_ADR_INDEX_PHASE_HIGH);
    assign wr_uh = cfg_wr && (cfg_addr == `IOF_ADR_COMM_PHASE_HIGH);
    assign wr_pl = cfg_wr && (cfg_addr == `IOF_ADR_PHASE_LOW_BITS);
    assign wr_fc = cfg_wr && (cfg_addr == `IOF_ADR_FILTER_CONFIG);
    assign wr_lt = cfg_wr && (cfg_addr == `IOF_ADR_LAG_THRESHOLD);
    assign wr_fk = cfg_wr && (cfg_addr == `IOF_ADR_FILTER_COEFF);
    assign kpmax_w = cfg_wdata[`IOF_FC_KPMAX_HI:`IOF_FC_KPMAX_LO];
    assign kp_w = cfg_wdata[`IOF_FK_KP_HI:0];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_ctl_q <= `IOF_RST_OUTPUT_CONTROL;
        end else if (wr_oc) begin
            out_ctl_q <= cfg_wdata;
        end
    end

    // Calibration has priority over a software write in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            zph_hi_q <= `IOF_RST_PHASE_HIGH;
            uvw_hi_q <= `IOF_RST_PHASE_HIGH;
            ph_lo_q <= `IOF_RST_PHASE_LOW;
        end else begin
            if (cal_index_wr) begin
                zph_hi_q <= cal_index_phase[9:2];
            end else if (wr_zh) begin
                zph_hi_q <= cfg_wdata;
            end
            if (wr_uh) begin
                uvw_hi_q <= cfg_wdata;
            end
            if (wr_pl) begin
                ph_lo_q[3:2] <= cfg_wdata[3:2];
            end
            if (cal_index_wr) begin
                ph_lo_q[1:0] <= cal_index_phase[1:0];
            end else if (wr_pl) begin
                ph_lo_q[1:0] <= cfg_wdata[1:0];
            end
        end
    end

    // A reserved gain limit leaves the stored limit unchanged.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            filter_config_q <= `IOF_RST_FILTER_CONFIG;
        end else if (wr_fc) begin
            filter_config_q[`IOF_FC_FB:0] <= cfg_wdata[`IOF_FC_FB:0];
            if (kpmax_w >= `IOF_KPMAX_MIN && kpmax_w <= `IOF_KPMAX_MAX) begin
                filter_config_q[`IOF_FC_KPMAX_HI:`IOF_FC_KPMAX_LO] <= kpmax_w;
            end
        end
    end

    // Threshold zero is reserved and is not stored.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lag_thr_q <= `IOF_RST_LAG_THRESHOLD;
        end else if (wr_lt && cfg_wdata[4:0] != 5'h00) begin
            lag_thr_q <= cfg_wdata[4:0];
        end
    end

    // ----------------------------------------
    // Filter coefficients and gain adaption
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ki_q <= `IOF_RST_KI;
        end else if (wr_fk) begin
            ki_q <= cfg_wdata[`IOF_FK_KI_HI:`IOF_FK_KI_LO];
        end
    end

    // In dynamic mode the adaption owns the proportional gain and software writes to it are dropped.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            kp_q <= `IOF_RST_KP;
        end else if (filter_config_q[`IOF_FC_AUTO]) begin
            if (lag_valid) begin
                if (filter_lag > lag_thr_q && kp_q != 3'h0) begin
                    kp_q <= kp_q - 3'h1;
                end else if (filter_lag < lag_thr_q
                             && kp_q < filter_config_q[`IOF_FC_KPMAX_HI:`IOF_FC_KPMAX_LO]) begin
                    kp_q <= kp_q + 3'h1;
                end
            end
        end else if (wr_fk && kp_w <= `IOF_KP_MAX) begin
            kp_q <= kp_w;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dynamic_gain_en <= 1'b0;
            gain_limit <= `IOF_KPMAX_MIN;
        end else begin
            dynamic_gain_en <= filter_config_q[`IOF_FC_AUTO];
            gain_limit <= filter_config_q[`IOF_FC_KPMAX_HI:`IOF_FC_KPMAX_LO];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            proportional_gain <= `IOF_RST_KP;
            integral_gain <= `IOF_RST_KI;
        end else begin
            proportional_gain <= kp_q;
            integral_gain <= ki_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lag_reduce_delay <= 4'h0;
        end else if (filter_config_q[`IOF_FC_FB]) begin
            lag_reduce_delay <= 4'(`IOF_FB_DELAY_CYCLES);
        end else begin
            lag_reduce_delay <= 4'h0;
        end
    end

    // ----------------------------------------
    // Phase values
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            index_phase_value <= 10'h000;
        end else begin
            index_phase_value <= {zph_hi_q, ph_lo_q[1:0]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            commutation_phase_shift <= 10'h000;
        end else begin
            commutation_phase_shift <= {uvw_hi_q, ph_lo_q[3:2]};
        end
    end

    // ----------------------------------------
    // Output conditioning
    // ----------------------------------------
    logic abz_en, uvw_en, a_dir, b_dir;
    logic v_seq, w_seq;

    assign abz_en = out_ctl_q[`IOF_OC_ABZEN];
    assign uvw_en = out_ctl_q[`IOF_OC_UVWEN];
    // Swapping A and B reverses the quadrature count direction.
    assign a_dir = out_ctl_q[`IOF_OC_ABZDIR] ? quad_b_raw : quad_a_raw;
    assign b_dir = out_ctl_q[`IOF_OC_ABZDIR] ? quad_a_raw : quad_b_raw;
    // Swapping V and W reverses the commutation sequence.
    assign v_seq = out_ctl_q[`IOF_OC_UVWDIR] ? comm_w_raw : comm_v_raw;
    assign w_seq = out_ctl_q[`IOF_OC_UVWDIR] ? comm_v_raw : comm_w_raw;

    // Disabled outputs sit low whatever their polarity settings say.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_a <= 1'b0;
            out_b <= 1'b0;
            out_index <= 1'b0;
        end else if (!abz_en) begin
            out_a <= 1'b0;
            out_b <= 1'b0;
            out_index <= 1'b0;
        end else begin
            if (index_raw) begin
                out_a <= out_ctl_q[`IOF_OC_APOL];
                out_b <= out_ctl_q[`IOF_OC_BPOL];
            end else begin
                out_a <= a_dir ^ out_ctl_q[`IOF_OC_APOL];
                out_b <= b_dir ^ out_ctl_q[`IOF_OC_BPOL];
            end
            out_index <= index_raw ^ out_ctl_q[`IOF_OC_ZPOL];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_u <= 1'b0;
            out_v <= 1'b0;
            out_w <= 1'b0;
        end else if (!uvw_en) begin
            out_u <= 1'b0;
            out_v <= 1'b0;
            out_w <= 1'b0;
        end else begin
            out_u <= comm_u_raw ^ out_ctl_q[`IOF_OC_UVWPOL];
            out_v <= v_seq ^ out_ctl_q[`IOF_OC_UVWPOL];
            out_w <= w_seq ^ out_ctl_q[`IOF_OC_UVWPOL];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            abz_enable <= 1'b0;
        end else begin
            abz_enable <= abz_en;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            uvw_enable <= 1'b0;
        end else begin
            uvw_enable <= uvw_en;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            readout_fast_rate <= 1'b0;
        end else begin
            readout_fast_rate <= abz_en;
        end
    end

    // ----------------------------------------
    // ADC snapshots
    // ----------------------------------------
    // An LFSR shortens each interval by up to 15 cycles so refreshes are irregular.
    iof_pkg::iof_tick_t snap_cnt_q;
    logic [7:0] lfsr_q;
    logic snap_tick;

    assign snap_tick = (snap_cnt_q == 10'h000);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lfsr_q <= 8'h01;
        end else begin
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            snap_cnt_q <= 10'(`IOF_SNAP_CYCLES - 1);
        end else if (snap_tick) begin
            snap_cnt_q <= 10'(`IOF_SNAP_CYCLES - 1) - {6'h00, lfsr_q[3:0]};
        end else begin
            snap_cnt_q <= snap_cnt_q - 10'h001;
        end
    end

    // Snapshots are never written from the access port.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            snap_sin_q <= 8'h00;
        end else if (snap_tick) begin
            snap_sin_q <= adc_sine[11:4];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            snap_cos_q <= 8'h00;
        end else if (snap_tick) begin
            snap_cos_q <= adc_cosine[11:4];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            snap_idx_q <= 8'h00;
        end else if (snap_tick) begin
            snap_idx_q <= adc_index;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    iof_pkg::iof_byte_t rd_mux;

    always_comb begin
        case (cfg_addr)
            `IOF_ADR_OUTPUT_CONTROL: rd_mux = out_ctl_q;
            `IOF_ADR_INDEX_PHASE_HIGH: rd_mux = zph_hi_q;
            `IOF_ADR_COMM_PHASE_HIGH: rd_mux = uvw_hi_q;
            `IOF_ADR_PHASE_LOW_BITS: rd_mux = {4'h0, ph_lo_q};
            `IOF_ADR_INDEX_ADC: rd_mux = snap_idx_q;
            `IOF_ADR_SINE_ADC: rd_mux = snap_sin_q;
            `IOF_ADR_COSINE_ADC: rd_mux = snap_cos_q;
            `IOF_ADR_FILTER_CONFIG: rd_mux = {3'h0, filter_config_q};
            `IOF_ADR_LAG_THRESHOLD: rd_mux = {3'h0, lag_thr_q};
            `IOF_ADR_FILTER_COEFF: rd_mux = {2'h0, ki_q, 1'b0, kp_q};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_q <= 8'h00;
            rack_q <= 1'b0;
        end else begin
            rack_q <= cfg_rd;
            if (cfg_rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign cfg_rdata = rdata_q;
    assign cfg_rack = rack_q;

endmodule : iof_regs
